// >>> hw/piu_top.sv
// prioritised interrupt unit: sources, option register, entry/return sequencing
// Function
// - one non-maskable source 0, maskable 1..4, fixed two-byte vectors descending
// - accepted request loads the program counter with the source vector
// - non-maskable pre-empts normal code and maskable routines but not itself; maskable never pre-empt each other
// - pending maskable served in fixed order, source 1 first, 4 last
// - global enable bit 4 gates maskable sources only
// - global enable clear blocks every wake-up, non-maskable included
// - non-maskable request caught in a flip-flop cleared on service entry
// - source 1 level sensitive when bit 6 set, falling edge otherwise
// - source 2 edge sensitive, bit 5 picks rising or falling
// - sources 3 and 4 always level sensitive
// - edge latch sets once, clears on routine start, extra edges dropped
// - lines sampled at instruction end; accepted request skips next instruction
// - three carry/zero pairs: normal, maskable, non-maskable, switched on entry
// - entry order: push pc, inhibit maskable, clear latch, load vector
// - return restores previous flag pair and pops the program counter
// - events ORed per source, per-event flags readable
// - option register write-only, byte writes only, reset to zero
// - maskable entry during first three cycles of zero write keeps normal flags
//
// Implementation choice: register access over AXI4-Lite.
module piu_top #(
  parameter int NPORT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_n,
  input wire logic [NPORT-1:0] port_pin,
  input wire logic spi_eot,
  input wire logic [1:0] tmr_ovf,
  input wire logic lfo_evt,
  input wire logic adc_eoc,
  input wire logic instr_end,
  input wire logic return_from_interrupt,
  input wire logic flag_we,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic instr_skip,
  output logic pc_push,
  output logic pc_pop,
  output logic vec_load,
  output logic [11:0] vec_addr,
  output logic carry_flag,
  output logic zero_flag,
  output logic [1:0] flag_ctx,
  output logic wake_req
);
  localparam int EVW = NPORT + 5;

  typedef struct packed {
    logic [2:0] nmi_s;
    logic nmi_lvl;
    logic nmi_prev;
    logic [NPORT-1:0] port_s1;
    logic [NPORT-1:0] port_s2;
    logic [NPORT-1:0] port_s3;
    logic [NPORT-1:0] port_lvl;
    logic line1_prev;
    logic line2_prev;
    logic latch1;
    logic latch2;
    logic nmi_latch;
    logic [7:0] opt;
    logic [2:0] zwr_cnt;
    piu_pkg::piu_ctx_t ctx;
    piu_pkg::piu_ctx_t fctx;
    piu_pkg::piu_ctx_t nmi_prev_ctx;
    piu_pkg::piu_ctx_t nmi_prev_f;
    logic [5:0] flags;
    piu_pkg::piu_seq_t seq;
    logic [2:0] sel;
    logic [11:0] vec;
    logic skip;
    logic pop;
    logic wake;
    logic [EVW-1:0] evf;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } piu_state_t;

  piu_state_t s_ff;
  piu_state_t nxt_s;

  logic gen;
  logic line1;
  logic line2;
  logic fall1;
  logic edge2;
  logic nmi_fall;
  logic [3:0] req;
  logic accept;
  logic accept_nmi;
  logic [2:0] pick;

  // request lines are active low; sources ORed onto one line each
  assign gen = s_ff.opt[piu_pkg::PIU_GEN_BIT];
  assign line1 = ~spi_eot;
  assign line2 = &s_ff.port_lvl;
  assign fall1 = s_ff.line1_prev & ~line1;
  assign edge2 = s_ff.opt[piu_pkg::PIU_ESB_BIT] ? (~s_ff.line2_prev & line2)
                                                : (s_ff.line2_prev & ~line2);
  assign nmi_fall = s_ff.nmi_prev & ~s_ff.nmi_lvl;

  // level sources are seen live, no copy kept; the requester must hold them
  always_comb
  begin
    req[0] = s_ff.opt[piu_pkg::PIU_LES_BIT] ? ~line1 : s_ff.latch1;
    req[1] = s_ff.latch2;
    req[2] = (|tmr_ovf) | lfo_evt;
    req[3] = adc_eoc;
  end

  // acceptance only at instruction end and only from an idle sequencer
  always_comb
  begin
    accept_nmi = instr_end && s_ff.seq == piu_pkg::PIU_SEQ_IDLE && s_ff.nmi_latch
                 && s_ff.ctx != piu_pkg::PIU_CTX_NMI;
    accept = accept_nmi || (instr_end && s_ff.seq == piu_pkg::PIU_SEQ_IDLE && gen
             && s_ff.ctx == piu_pkg::PIU_CTX_NORM && (|req));
    if (accept_nmi)
      pick = 3'h0;
    else if (req[0])
      pick = 3'h1;
    else if (req[1])
      pick = 3'h2;
    else if (req[2])
      pick = 3'h3;
    else
      pick = 3'h4;
  end

  // all next-state logic of the block
  always_comb
  begin
    logic [EVW-1:0] ev_set;
    logic [EVW-1:0] ev_clr;
    logic [31:0] rd;
    logic rd_ok;
    ev_set = '0;
    ev_clr = '0;
    rd = '0;
    rd_ok = 1'b1;
    nxt_s = s_ff;
    nxt_s.skip = 1'b0;
    nxt_s.pop = 1'b0;
    // pins pass three flops; a change counts once stages two and three agree
    nxt_s.nmi_s = {s_ff.nmi_s[1:0], nmi_n};
    if (s_ff.nmi_s[1] == s_ff.nmi_s[2])
      nxt_s.nmi_lvl = s_ff.nmi_s[2];
    nxt_s.nmi_prev = s_ff.nmi_lvl;
    nxt_s.port_s1 = port_pin;
    nxt_s.port_s2 = s_ff.port_s1;
    nxt_s.port_s3 = s_ff.port_s2;
    for (int i = 0; i < NPORT; i++)
    begin
      if (s_ff.port_s2[i] == s_ff.port_s3[i])
        nxt_s.port_lvl[i] = s_ff.port_s3[i];
    end
    nxt_s.line1_prev = line1;
    nxt_s.line2_prev = line2;

    // entry sequence; clear precedes set so a fresh edge is never lost
    case (s_ff.seq)
      piu_pkg::PIU_SEQ_IDLE:
      begin
        if (accept)
        begin
          nxt_s.seq = piu_pkg::PIU_SEQ_PUSH;
          nxt_s.sel = pick;
          nxt_s.skip = 1'b1;
          if (accept_nmi)
          begin
            nxt_s.nmi_prev_ctx = s_ff.ctx;
            nxt_s.nmi_prev_f = s_ff.fctx;
            nxt_s.ctx = piu_pkg::PIU_CTX_NMI;
            nxt_s.fctx = piu_pkg::PIU_CTX_NMI;
          end
          else
          begin
            nxt_s.ctx = piu_pkg::PIU_CTX_IRQ;
            // zero write still in flight: flags stay on the normal pair
            if (s_ff.zwr_cnt == 3'h0)
              nxt_s.fctx = piu_pkg::PIU_CTX_IRQ;
          end
        end
        else if (return_from_interrupt && s_ff.ctx != piu_pkg::PIU_CTX_NORM)
        begin
          nxt_s.pop = 1'b1;
          if (s_ff.ctx == piu_pkg::PIU_CTX_NMI)
          begin
            nxt_s.ctx = s_ff.nmi_prev_ctx;
            nxt_s.fctx = s_ff.nmi_prev_f;
          end
          else
          begin
            nxt_s.ctx = piu_pkg::PIU_CTX_NORM;
            nxt_s.fctx = piu_pkg::PIU_CTX_NORM;
          end
        end
      end
      piu_pkg::PIU_SEQ_PUSH:
        nxt_s.seq = piu_pkg::PIU_SEQ_INHIB;
      piu_pkg::PIU_SEQ_INHIB:
        nxt_s.seq = piu_pkg::PIU_SEQ_CLR;
      piu_pkg::PIU_SEQ_CLR:
      begin
        nxt_s.seq = piu_pkg::PIU_SEQ_LOAD;
        case (s_ff.sel)
          3'h0:
          begin
            nxt_s.nmi_latch = 1'b0;
            nxt_s.vec = piu_pkg::PIU_VEC0;
          end
          3'h1:
          begin
            nxt_s.latch1 = 1'b0;
            nxt_s.vec = piu_pkg::PIU_VEC1;
          end
          3'h2:
          begin
            nxt_s.latch2 = 1'b0;
            nxt_s.vec = piu_pkg::PIU_VEC2;
          end
          3'h3:
            nxt_s.vec = piu_pkg::PIU_VEC3;
          default:
            nxt_s.vec = piu_pkg::PIU_VEC4;
        endcase
      end
      piu_pkg::PIU_SEQ_LOAD:
        nxt_s.seq = piu_pkg::PIU_SEQ_IDLE;
      default:
        nxt_s.seq = piu_pkg::PIU_SEQ_IDLE;
    endcase

    // a single stored request per edge source; further edges merge into it
    if (nmi_fall)
      nxt_s.nmi_latch = 1'b1;
    if (fall1 && !s_ff.opt[piu_pkg::PIU_LES_BIT])
      nxt_s.latch1 = 1'b1;
    if (edge2)
      nxt_s.latch2 = 1'b1;

    // wake-up needs the global enable, even for the non-maskable source
    nxt_s.wake = gen && (s_ff.nmi_latch || (|req));

    // flag pair being written is the one now in use
    if (flag_we)
    begin
      case (s_ff.fctx)
        piu_pkg::PIU_CTX_IRQ:
          nxt_s.flags[3:2] = {zero_in, carry_in};
        piu_pkg::PIU_CTX_NMI:
          nxt_s.flags[5:4] = {zero_in, carry_in};
        default:
          nxt_s.flags[1:0] = {zero_in, carry_in};
      endcase
    end

    // per-event sticky flags for polling, write one to clear, set wins
    ev_set = {~s_ff.port_lvl, adc_eoc, lfo_evt, tmr_ovf, spi_eot};

    // zero write to the option register lands on its fourth cycle
    if (s_ff.zwr_cnt != 3'h0)
    begin
      if (s_ff.zwr_cnt == piu_pkg::PIU_ZWR_CYCLES - 3'h1)
      begin
        nxt_s.opt = 8'h00;
        nxt_s.zwr_cnt = 3'h0;
      end
      else
        nxt_s.zwr_cnt = s_ff.zwr_cnt + 3'h1;
    end

    // write channel: address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_s.aw_have = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = s_axi_wdata[7:0];
      nxt_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s_ff.aw_have && s_ff.w_have)
    begin
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = piu_pkg::PIU_RESP_OKAY;
      case ({s_ff.awaddr[7:2], 2'b00})
        piu_pkg::PIU_OPT_OFS:
        begin
          // whole-byte write only; no bit-level access path exists
          if (s_ff.wstrb0 && s_ff.zwr_cnt == 3'h0)
          begin
            if (s_ff.wdata == 8'h00)
              nxt_s.zwr_cnt = 3'h1;
            else
              nxt_s.opt = s_ff.wdata;
          end
        end
        piu_pkg::PIU_EVT_OFS:
          ev_clr = s_ff.wstrb0 ? EVW'(s_ff.wdata) : '0; // port flags above bit 7 can never be cleared by a write
        piu_pkg::PIU_STAT_OFS:
          nxt_s.bresp = piu_pkg::PIU_RESP_OKAY;
        default:
          nxt_s.bresp = piu_pkg::PIU_RESP_SLVERR;
      endcase
    end
    if (s_ff.bvalid && s_axi_bready)
      nxt_s.bvalid = 1'b0;
    nxt_s.evf = (s_ff.evf & ~ev_clr) | ev_set;

    // read channel; option register is write-only and reads as zero
    case ({s_axi_araddr[7:2], 2'b00})
      piu_pkg::PIU_OPT_OFS:
        rd = '0;
      piu_pkg::PIU_STAT_OFS:
        rd = {16'h0000, s_ff.wake, s_ff.latch2, s_ff.latch1, s_ff.nmi_latch,
              s_ff.fctx, s_ff.ctx, s_ff.opt};
      piu_pkg::PIU_EVT_OFS:
        rd = {{(32-EVW){1'b0}}, s_ff.evf};
      default:
        rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd;
      nxt_s.rresp = rd_ok ? piu_pkg::PIU_RESP_OKAY : piu_pkg::PIU_RESP_SLVERR;
    end
    else if (s_ff.rvalid && s_axi_rready)
      nxt_s.rvalid = 1'b0;
  end

  // state register; reset clears the option byte, masking every maskable source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_ff <= '0;
      s_ff.nmi_s <= 3'h7;
      s_ff.nmi_lvl <= 1'b1;
      s_ff.nmi_prev <= 1'b1;
      s_ff.port_s1 <= '1;
      s_ff.port_s2 <= '1;
      s_ff.port_s3 <= '1;
      s_ff.port_lvl <= '1;
      s_ff.line1_prev <= 1'b1;
      s_ff.line2_prev <= 1'b1;
      s_ff.opt <= piu_pkg::PIU_OPT_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign s_axi_awready = ~s_ff.aw_have & ~s_ff.bvalid;
  assign s_axi_wready = ~s_ff.w_have & ~s_ff.bvalid;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = ~s_ff.rvalid;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign instr_skip = s_ff.skip;
  assign pc_push = s_ff.seq == piu_pkg::PIU_SEQ_PUSH;
  assign vec_load = s_ff.seq == piu_pkg::PIU_SEQ_LOAD;
  assign vec_addr = s_ff.vec;
  assign pc_pop = s_ff.pop;
  assign flag_ctx = s_ff.fctx;
  assign carry_flag = s_ff.flags[{s_ff.fctx, 1'b0}];
  assign zero_flag = s_ff.flags[{s_ff.fctx, 1'b1}];
  assign wake_req = s_ff.wake;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_VEC_MATCH: assert property (vec_load && s_ff.sel == 3'h0 |-> vec_addr == 12'hffc)
    else $error("wrong nmi vector");
  AST_LOAD_AFTER_ACCEPT: assert property (accept |-> ##4 vec_load)
    else $error("vector not loaded four cycles after accept");
  AST_NO_NEST: assert property (accept && !accept_nmi |-> s_ff.ctx == piu_pkg::PIU_CTX_NORM)
    else $error("maskable entered over a routine");
  AST_PRIO: assert property (accept && !accept_nmi && req[0] |=> s_ff.sel == 3'h1)
    else $error("source 1 not first");
  AST_GEN_GATE: assert property (!gen && !s_ff.nmi_latch |=> s_ff.seq == piu_pkg::PIU_SEQ_IDLE)
    else $error("maskable taken while disabled");
  AST_WAKE_GEN: assert property (!gen |=> !wake_req)
    else $error("wake while disabled");
  AST_NMI_CLR: assert property (s_ff.seq == piu_pkg::PIU_SEQ_CLR && s_ff.sel == 3'h0 && !nmi_fall
    |=> !s_ff.nmi_latch)
    else $error("nmi latch not cleared");
  AST_ORDER: assert property (pc_push |=> s_ff.seq == piu_pkg::PIU_SEQ_INHIB ##1
    s_ff.seq == piu_pkg::PIU_SEQ_CLR ##1 vec_load)
    else $error("entry order broken");
  AST_NMI_FLAGS: assert property (accept_nmi |=> flag_ctx == piu_pkg::PIU_CTX_NMI)
    else $error("nmi flag pair not selected");
  AST_RETURN_FROM_INTERRUPT: assert property (s_ff.seq == piu_pkg::PIU_SEQ_IDLE && !accept && return_from_interrupt
    && s_ff.ctx == piu_pkg::PIU_CTX_IRQ |=> pc_pop && flag_ctx == piu_pkg::PIU_CTX_NORM)
    else $error("return did not restore");
  AST_ZWR: assert property (accept && !accept_nmi && s_ff.zwr_cnt != 3'h0
    && s_ff.fctx == piu_pkg::PIU_CTX_NORM |=> flag_ctx == piu_pkg::PIU_CTX_NORM)
    else $error("flags switched during zero write");
  CVR_NMI: cover property (accept_nmi ##4 vec_load);
  CVR_PREEMPT: cover property (s_ff.ctx == piu_pkg::PIU_CTX_IRQ && accept_nmi);
  CVR_ZWR: cover property (accept && s_ff.zwr_cnt != 3'h0);
endmodule : piu_top

// >>> hw/piu_pkg.sv
// constants shared by the prioritised interrupt unit
package piu_pkg;
  // register byte addresses on the AXI4-Lite port, and the option register reset value
  localparam logic [7:0] PIU_OPT_OFS = 8'hc8;
  localparam logic [7:0] PIU_STAT_OFS = 8'hcc;
  localparam logic [7:0] PIU_EVT_OFS = 8'hd0;
  localparam logic [7:0] PIU_OPT_RST = 8'h00;
  // option register fields
  localparam int PIU_GEN_BIT = 4;
  localparam int PIU_ESB_BIT = 5;
  localparam int PIU_LES_BIT = 6;
  // vector addresses in program space, source 0 highest
  localparam logic [11:0] PIU_VEC0 = 12'hffc;
  localparam logic [11:0] PIU_VEC1 = 12'hff6;
  localparam logic [11:0] PIU_VEC2 = 12'hff4;
  localparam logic [11:0] PIU_VEC3 = 12'hff2;
  localparam logic [11:0] PIU_VEC4 = 12'hff0;
  // cycles of a zero write to the option register
  localparam logic [2:0] PIU_ZWR_CYCLES = 3'h4;
  // context and flag pair codes
  typedef enum logic [1:0] {PIU_CTX_NORM = 2'h0, PIU_CTX_IRQ = 2'h1, PIU_CTX_NMI = 2'h2} piu_ctx_t;
  // entry sequence, gray coded
  typedef enum logic [2:0]
  {
    PIU_SEQ_IDLE = 3'h0,
    PIU_SEQ_PUSH = 3'h1,
    PIU_SEQ_INHIB = 3'h3,
    PIU_SEQ_CLR = 3'h2,
    PIU_SEQ_LOAD = 3'h6
  } piu_seq_t;
  localparam logic [1:0] PIU_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIU_RESP_SLVERR = 2'h2;
endpackage : piu_pkg

// >>> bench/piu_core_model.sv
// core sequencer stand-in: instruction-end, return and flag-write strobes
module piu_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic end_go,
  input wire logic ret_go,
  input wire logic slow,
  input wire logic wr_go,
  input wire logic [1:0] cz,
  output logic instr_end,
  output logic return_from_interrupt,
  output logic flag_we,
  output logic carry_in,
  output logic zero_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] end_ff;
  // slow mode stretches the instruction by two cycles before it ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      end_ff <= 3'h0;
      return_from_interrupt <= 1'b0;
      flag_we <= 1'b0;
    end
    else
    begin
      end_ff <= {end_ff[1:0], end_go};
      return_from_interrupt <= ret_go;
      flag_we <= wr_go;
    end
  end
  assign instr_end = slow ? end_ff[2] : end_ff[0];
  // data only holds meaning with the strobe, so show the inverse outside it
  assign carry_in = flag_we ? cz[1] : ~cz[1];
  assign zero_in = flag_we ? cz[0] : ~cz[0];
endmodule : piu_core_model

// >>> bench/piu_top_tb.sv
// self-checking bench for the prioritised interrupt unit
module piu_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, port_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, tmr_ovf, flag_ctx, cz;
  logic nmi_n, spi_eot, lfo_evt, adc_eoc, instr_end, return_from_interrupt, flag_we;
  logic carry_in, zero_in, instr_skip, pc_push, pc_pop, vec_load, carry_flag, zero_flag;
  logic wake_req, end_go, ret_go, slow, wr_go;
  logic [11:0] vec_addr;
  int n_errors = 0;
  int num_checks = 0;

  piu_top piu_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nmi_n, .port_pin, .spi_eot, .tmr_ovf, .lfo_evt, .adc_eoc,
    .instr_end, .return_from_interrupt, .flag_we, .carry_in, .zero_in, .instr_skip, .pc_push,
    .pc_pop, .vec_load, .vec_addr, .carry_flag, .zero_flag, .flag_ctx, .wake_req);
  piu_core_model piu_core_model_i (.aclk, .aresetn, .end_go, .ret_go, .slow, .wr_go, .cz,
    .instr_end, .return_from_interrupt, .flag_we, .carry_in, .zero_in);

  // 20 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // verdict in one place
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // a wait that runs out is a mismatch and ends the run
  task automatic stuck(input string what);
    n_errors++;
    $display("[FAIL] %0t %s timed out", $time, what);
    close_out();
  endtask : stuck

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "write response");
        // let an edge pass so a following call never reassigns bready in this step
        @(posedge aclk);
        return;
      end
    end
    stuck("write");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    d = 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er, "read response");
        @(posedge aclk);
        return;
      end
    end
    stuck("read");
  endtask : axi_rd

  // one instruction end; watch push before vector load, skip and context
  task automatic step(input logic en, input logic [11:0] vec, input logic [1:0] ctx);
    logic push, skip, load;
    logic [11:0] got;
    push = 1'b0;
    skip = 1'b0;
    load = 1'b0;
    got = 12'h0;
    end_go <= 1'b1;
    @(posedge aclk);
    end_go <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge aclk);
      if (vec_load === 1'b1 && !load)
      begin
        load = 1'b1;
        got = vec_addr;
        chk(push, 1'b1, "push before load");
      end
      push = push | (pc_push === 1'b1);
      skip = skip | (instr_skip === 1'b1);
    end
    chk({load, skip}, {en, en}, "entry and skip");
    if (en) chk(got, vec, "vector");
    chk(flag_ctx, ctx, "context after entry");
  endtask : step

  task automatic ret(input logic [1:0] ctx);
    logic pop;
    pop = 1'b0;
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge aclk);
      pop = pop | (pc_pop === 1'b1);
    end
    chk(pop, 1'b1, "pc pop");
    chk(flag_ctx, ctx, "context after return");
  endtask : ret

  // reset value, write-only readback, byte lane 0 needed, unmapped place
  task automatic t_regs;
    logic [31:0] d;
    axi_rd(piu_pkg::PIU_STAT_OFS, d, piu_pkg::PIU_RESP_OKAY);
    chk(d & 32'h3ff, 32'h0, "status after reset");
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h10, 4'hf, piu_pkg::PIU_RESP_OKAY);
    axi_rd(piu_pkg::PIU_OPT_OFS, d, piu_pkg::PIU_RESP_OKAY);
    chk(d, 32'h0, "option reads zero");
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h70, 4'he, piu_pkg::PIU_RESP_OKAY);
    axi_rd(piu_pkg::PIU_STAT_OFS, d, piu_pkg::PIU_RESP_OKAY);
    chk(d[7:0], 8'h10, "option copy");
    axi_rd(8'he0, d, piu_pkg::PIU_RESP_SLVERR);
    axi_wr(8'he0, 8'h00, 4'hf, piu_pkg::PIU_RESP_SLVERR);
  endtask : t_regs

  // maskable sources 1, 3 and 4 at once, nmi nested, flag pairs swapped
  task automatic t_prio;
    logic [31:0] d;
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h50, 4'hf, piu_pkg::PIU_RESP_OKAY);
    spi_eot <= 1'b1;
    tmr_ovf <= 2'h1;
    adc_eoc <= 1'b1;
    wr_go <= 1'b1;
    cz <= 2'h2;
    @(posedge aclk);
    wr_go <= 1'b0;
    cyc(2);
    chk(wake_req, 1'b1, "wake with enable");
    chk({carry_flag, zero_flag}, 2'h2, "normal pair");
    axi_rd(piu_pkg::PIU_EVT_OFS, d, piu_pkg::PIU_RESP_OKAY);
    chk(d[4:0], 5'h13, "event flags");
    step(1'b1, piu_pkg::PIU_VEC1, 2'h1);
    chk({carry_flag, zero_flag}, 2'h0, "irq pair");
    spi_eot <= 1'b0;
    step(1'b0, 12'h0, 2'h1);
    nmi_n <= 1'b0;
    cyc(6);
    step(1'b1, piu_pkg::PIU_VEC0, 2'h2);
    nmi_n <= 1'b1;
    ret(2'h1);
    ret(2'h0);
    chk({carry_flag, zero_flag}, 2'h2, "normal pair back");
    step(1'b1, piu_pkg::PIU_VEC3, 2'h1);
    tmr_ovf <= 2'h0;
    ret(2'h0);
    slow <= 1'b1;
    step(1'b1, piu_pkg::PIU_VEC4, 2'h1);
    adc_eoc <= 1'b0;
    slow <= 1'b0;
    ret(2'h0);
  endtask : t_prio

  // edge capture on sources 1 and 2, falling edge on source 1, both polarities on source 2, repeated edges
  task automatic t_edges;
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h10, 4'hf, piu_pkg::PIU_RESP_OKAY);
    spi_eot <= 1'b1;
    cyc(2);
    spi_eot <= 1'b0;
    cyc(2);
    step(1'b1, piu_pkg::PIU_VEC1, 2'h1);
    ret(2'h0);
    port_pin <= 4'he;
    cyc(2);
    port_pin <= 4'hf;
    cyc(2);
    port_pin <= 4'h7;
    cyc(2);
    port_pin <= 4'hf;
    cyc(6);
    step(1'b1, piu_pkg::PIU_VEC2, 2'h1);
    ret(2'h0);
    step(1'b0, 12'h0, 2'h0);
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h30, 4'hf, piu_pkg::PIU_RESP_OKAY);
    port_pin <= 4'hb;
    cyc(6);
    step(1'b0, 12'h0, 2'h0);
    port_pin <= 4'hf;
    cyc(6);
    step(1'b1, piu_pkg::PIU_VEC2, 2'h1);
    ret(2'h0);
  endtask : t_edges

  // global enable clear: maskable ignored, nmi still enters but never wakes
  task automatic t_mask;
    axi_wr(piu_pkg::PIU_OPT_OFS, 8'h00, 4'hf, piu_pkg::PIU_RESP_OKAY);
    cyc(6);
    adc_eoc <= 1'b1;
    nmi_n <= 1'b0;
    cyc(6);
    chk(wake_req, 1'b0, "no wake without enable");
    step(1'b1, piu_pkg::PIU_VEC0, 2'h2);
    nmi_n <= 1'b1;
    ret(2'h0);
    step(1'b0, 12'h0, 2'h0);
    adc_eoc <= 1'b0;
  endtask : t_mask

  // reset for five cycles, then the scenarios in turn
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {spi_eot, lfo_evt, adc_eoc, end_go, ret_go, slow, wr_go} = 7'h0;
    nmi_n = 1'b1;
    port_pin = 4'hf;
    tmr_ovf = 2'h0;
    cz = 2'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prio();
    t_edges();
    t_mask();
    close_out();
  end
endmodule : piu_top_tb
